// file: pkg/ncs_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef NCS_DEFINES_VH
`define NCS_DEFINES_VH

// apb byte addresses of the block's registers
`define NCS_ADDR_CONFIG     12'h000
`define NCS_ADDR_SUBADDR    12'h004
`define NCS_ADDR_SETUP1     12'h008
`define NCS_ADDR_CONTROL    12'h00c
`define NCS_ADDR_IRQSTAT    12'h010
`define NCS_ADDR_IRQMASK    12'h014
`define NCS_ADDR_DIAG       12'h018

// configuration register fields
`define NCS_CFG_SWRESET     7
`define NCS_CFG_TXGATE      5
`define NCS_CFG_ETHIGH      4
`define NCS_CFG_ETLOW       3
`define NCS_CFG_SHARED      2

// first setup register fields
`define NCS_SU1_PDSTYLE     7
`define NCS_SU1_NACK4       6

// control register fields (driver-enable and pulse transmit requests)
`define NCS_CTL_TXACTIVE    0
`define NCS_CTL_PULSEA      1
`define NCS_CTL_PULSEB      2

// reset values
`define NCS_CONFIG_RST      8'h00
`define NCS_SETUP1_RST      8'h00

// nack thresholds
`define NCS_NACK_FEW        8'h04
`define NCS_NACK_MANY       8'h80

// timer figures in nanoseconds (reconfiguration in milliseconds), reference is 20 MHz timing
`define NCS_RESP0_NS        596600
`define NCS_RESP1_NS        298400
`define NCS_RESP2_NS        149200
`define NCS_RESP3_NS        37400
`define NCS_IDLE0_NS        656000
`define NCS_IDLE1_NS        328000
`define NCS_IDLE2_NS        164000
`define NCS_IDLE3_NS        41000
`define NCS_RECON_LONG_MS   840
`define NCS_RECON_SHORT_MS  420
`define NCS_CLK_NS          10
`define NCS_CYC_PER_MS      100000

`endif

// file: src/ncs_net_config_setup_regs.v
// network configuration and first setup register bank with apb slave
//
// Overview of operation
// - gate low holds driver enable, pulses inactive, except pulse b in shared-bus mode
// - gate high lets transmit outputs follow activity
// - reset clears the transmit gate
// - timeout code 00 gives 596.6us, 656us, 840ms
// - codes 01/10 halve/quarter response and idle
// - code 11 gives 37.4us, 41us, 420ms
// - select bits pick register at address 07
// - low select bits shared; config write clears top
// - software reset leaves configuration untouched
// - shared bus: style bit picks push-pull or open-drain
// - style bit resets to open-drain
// - nack bit one: flag after four refusals
// - nack bit zero: flag after 128 refusals
`timescale 1ns/1ps
`include "ncs_defines.vh"
//
// register map, one 32-bit word per register, data in bits 7:0 (diagnostics in 8:0)
//   0x000  network configuration: soft reset, gate, timeouts,
//          shared-bus mode and the two low select bits
//   0x004  sub-address: the same two low select bits plus the
//          third; bits 7:3 read zero
//   0x008  first setup: pulse driver style and nack threshold
//   0x00c  transmit activity: stands in for the transmitter's
//          driver-enable and pulse requests
//   0x010  interrupt status, sticky, cleared by a read
//   0x014  interrupt mask, same layout as the status
//   0x018  diagnostics, read only: excess flag and counter
//   any other address answers with an error and reads zero
//
// interrupt sources
//   bit 0  transmit gate went from 0 to 1
//   bit 1  excess refusal flag was raised
//
// bus timing
//   a request is taken on the first access edge, pready follows
//   one cycle later and stands for one cycle; writes land at the
//   taking edge, so a read right after a write sees the new value
//   back-to-back transfers need no idle cycle between them
//
// timing of the decoded settings
//   every output is registered, so the transmit outputs and the
//   timer lengths follow a register write by one cycle
//   timer lengths are whole clock cycles, rounded down from the
//   printed microsecond figures at a 10 ns clock
//   reconfiguration lengths are parameters so that a test can
//   shrink them; the defaults are the full millisecond figures
//
// reset
//   a hardware reset clears the bank's registers and puts the outputs at idle levels and code 00 timings; the gate starts
//   low and the pulse a driver starts push-pull outside
//   shared-bus mode and open-drain inside it
//
// limitations
//   the excess refusal flag clears only on a hardware reset, as
//   the diagnostic read clear lives elsewhere in the controller
//   the soft reset bit is only passed on; it never touches this
//   bank, so software can set it without losing its settings
//   a refusal high for a single clock is counted; the input passes
//   a two-stage synchroniser and only its rising edge is used

module ncs_net_config_setup_regs #(
    parameter RECON_LONG_CYC  = `NCS_RECON_LONG_MS * `NCS_CYC_PER_MS,
    parameter RECON_SHORT_CYC = `NCS_RECON_SHORT_MS * `NCS_CYC_PER_MS
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        nackSeen,
    output reg         lineOutA_n,
    output reg         lineOutAOe,
    output reg         lineOutB_n,
    output reg         driverEnable_n,
    output reg         softReset,
    output reg  [1:0]  registerSelectBits,
    output reg         registerSelectTop,
    output reg  [31:0] responseCycles,
    output reg  [31:0] idleCycles,
    output reg  [31:0] reconfigCycles,
    output reg         irq
);

    // timer cycle counts derived from the printed figures, rounded down
    localparam [31:0] RESP0_CYC = `NCS_RESP0_NS / `NCS_CLK_NS;
    localparam [31:0] RESP1_CYC = `NCS_RESP1_NS / `NCS_CLK_NS;
    localparam [31:0] RESP2_CYC = `NCS_RESP2_NS / `NCS_CLK_NS;
    localparam [31:0] RESP3_CYC = `NCS_RESP3_NS / `NCS_CLK_NS;
    localparam [31:0] IDLE0_CYC = `NCS_IDLE0_NS / `NCS_CLK_NS;
    localparam [31:0] IDLE1_CYC = `NCS_IDLE1_NS / `NCS_CLK_NS;
    localparam [31:0] IDLE2_CYC = `NCS_IDLE2_NS / `NCS_CLK_NS;
    localparam [31:0] IDLE3_CYC = `NCS_IDLE3_NS / `NCS_CLK_NS;
    localparam [31:0] RECL_CYC  = RECON_LONG_CYC;
    localparam [31:0] RECS_CYC  = RECON_SHORT_CYC;

    // apb access states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;

    reg  [7:0]  config_q;        // configuration register
    reg         selTop_q;        // third select bit
    reg  [7:0]  setup1_q;        // first setup register
    reg  [2:0]  control_q;       // transmit activity requests
    reg         excess_refusal_flag_q;        // excessive refusal flag
    reg  [7:0]  nackCount_q;     // refusal counter
    reg  [1:0]  irqStat_q;       // sticky events
    reg  [1:0]  irqMask_q;       // event mask
    reg  [1:0]  state_q;         // access phase tracker
    reg  [1:0]  nackSync_q;      // refusal input synchroniser
    reg         nackPrev_q;      // edge detector history
    reg         gatePrev_q;      // gate history for event
    reg  [31:0] rdata_d;         // read mux
    reg         hit_d;           // address mapped

    // an access is taken only from idle, so a master that keeps
    // penable high across the answer cannot trigger a second one
    wire        access   = psel & penable & (state_q == ST_IDLE);
    wire        wrAccess = access & pwrite;
    wire        rdAccess = access & ~pwrite;
    wire        nackPulse = nackSync_q[1] & ~nackPrev_q;
    wire        txGate   = config_q[`NCS_CFG_TXGATE];
    wire        shared   = config_q[`NCS_CFG_SHARED];
    wire [1:0]  etCode   = {config_q[`NCS_CFG_ETHIGH],
                            config_q[`NCS_CFG_ETLOW]};
    wire [7:0]  nackLimit;
    wire        flagRise = nackPulse & ~excess_refusal_flag_q &
                           (nackCount_q + 8'h01 >= nackLimit);
    wire [1:0]  events   = {flagRise, txGate & ~gatePrev_q};

    // threshold chosen by the setup bit
    assign nackLimit = setup1_q[`NCS_SU1_NACK4] ? `NCS_NACK_FEW
                                                : `NCS_NACK_MANY;

    // response time for a timeout code
    function [31:0] respFor;
        input [1:0] code;
        begin
            case (code)
                2'b00:   respFor = RESP0_CYC;
                2'b01:   respFor = RESP1_CYC;
                2'b10:   respFor = RESP2_CYC;
                default: respFor = RESP3_CYC;
            endcase
        end
    endfunction

    // idle time for a timeout code
    function [31:0] idleFor;
        input [1:0] code;
        begin
            case (code)
                2'b00:   idleFor = IDLE0_CYC;
                2'b01:   idleFor = IDLE1_CYC;
                2'b10:   idleFor = IDLE2_CYC;
                default: idleFor = IDLE3_CYC;
            endcase
        end
    endfunction

    // read mux; reserved bits read zero
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        case (paddr)
            `NCS_ADDR_CONFIG:  rdata_d[7:0] = config_q;
            `NCS_ADDR_SUBADDR: rdata_d[2:0] = {selTop_q,
                                               config_q[1:0]};
            `NCS_ADDR_SETUP1:  rdata_d[7:0] = setup1_q;
            `NCS_ADDR_CONTROL: rdata_d[2:0] = control_q;
            `NCS_ADDR_IRQSTAT: rdata_d[1:0] = irqStat_q;
            `NCS_ADDR_IRQMASK: rdata_d[1:0] = irqMask_q;
            `NCS_ADDR_DIAG:    rdata_d[8:0] = {excess_refusal_flag_q, nackCount_q};
            // unmapped: flag an error, read zero
            default:           hit_d = 1'b0;
        endcase
    end

    // apb slave: one wait state, answer in the second access cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // first access cycle: latch the answer
                    if (access) begin
                        state_q <= ST_DONE;
                        pready  <= 1'b1;
                        pslverr <= ~hit_d;
                        prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
                    end
                end
                ST_DONE: begin
                    // answer stood one cycle; drop it
                    state_q <= ST_IDLE;
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    pready  <= 1'b0;
                end
            endcase
        end
    end

    // register writes; software reset bit never clears this bank
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            config_q  <= `NCS_CONFIG_RST;
            selTop_q  <= 1'b0;
            setup1_q  <= `NCS_SETUP1_RST;
            control_q <= 3'h0;
            irqMask_q <= 2'h0;
        end else if (wrAccess) begin
            case (paddr)
                `NCS_ADDR_CONFIG: begin
                    config_q <= pwdata[7:0];
                    selTop_q <= 1'b0;
                end
                `NCS_ADDR_SUBADDR: begin
                    config_q[1:0] <= pwdata[1:0];
                    selTop_q      <= pwdata[2];
                end
                `NCS_ADDR_SETUP1:  setup1_q  <= pwdata[7:0];
                `NCS_ADDR_CONTROL: control_q <= pwdata[2:0];
                `NCS_ADDR_IRQMASK: irqMask_q <= pwdata[1:0];
                // unmapped or read-only: the write is ignored
                default: ;
            endcase
        end
    end

    // refusal input synchroniser and edge detection
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nackSync_q <= 2'b00;
            nackPrev_q <= 1'b0;
        end else begin
            nackSync_q <= {nackSync_q[0], nackSeen};
            nackPrev_q <= nackSync_q[1];
        end
    end

    // refusal counter; flag is cleared only by hardware reset here
    // because the diagnostic register clearing lies outside this block
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nackCount_q <= 8'h00;
            excess_refusal_flag_q    <= 1'b0;
        end else if (nackPulse && !excess_refusal_flag_q) begin
            // the refusal that reaches the threshold raises the flag
            if (flagRise) begin
                excess_refusal_flag_q    <= 1'b1;
                nackCount_q <= 8'h00;
            end else begin
                nackCount_q <= nackCount_q + 8'h01;
            end
        end
    end

    // sticky interrupt status; a read clears, a new event wins
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqStat_q  <= 2'h0;
            gatePrev_q <= 1'b0;
            irq        <= 1'b0;
        end else begin
            gatePrev_q <= txGate;
            // the read sees the old value; an event in the same cycle
            // survives the clear so that nothing is lost
            if (rdAccess && paddr == `NCS_ADDR_IRQSTAT)
                irqStat_q <= events;
            else
                irqStat_q <= irqStat_q | events;
            // uses old status or the event, so irq rises with the event and drops a cycle after a read clear
            irq <= |((irqStat_q | events) & irqMask_q);
        end
    end

    // transmit outputs, registered; shared-bus mode leaves pulse b
    // ungated since its pin serves another purpose there
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lineOutA_n     <= 1'b1;
            lineOutAOe     <= 1'b0;
            lineOutB_n     <= 1'b1;
            driverEnable_n <= 1'b1;
        end else begin
            // driver enable and pulse b are plain active-low outputs
            driverEnable_n <= ~(txGate &
                                control_q[`NCS_CTL_TXACTIVE]);
            lineOutB_n <= ~(control_q[`NCS_CTL_PULSEB] &
                            (txGate | shared));
            if (shared && !setup1_q[`NCS_SU1_PDSTYLE]) begin
                // open-drain: drive only the low level
                lineOutA_n <= 1'b0;
                lineOutAOe <= txGate &
                              control_q[`NCS_CTL_PULSEA];
            end else begin
                lineOutA_n <= ~(txGate &
                                control_q[`NCS_CTL_PULSEA]);
                lineOutAOe <= 1'b1;
            end
        end
    end

    // decoded settings exported to the rest of the controller
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            softReset          <= 1'b0;
            registerSelectBits <= 2'b00;
            registerSelectTop  <= 1'b0;
            responseCycles     <= RESP0_CYC;
            idleCycles         <= IDLE0_CYC;
            reconfigCycles     <= RECL_CYC;
        end else begin
            // a copy only; the soft reset bit leaves this bank alone
            softReset          <= config_q[`NCS_CFG_SWRESET];
            registerSelectBits <= config_q[1:0];
            registerSelectTop  <= selTop_q;
            responseCycles     <= respFor(etCode);
            idleCycles         <= idleFor(etCode);
            reconfigCycles     <= (etCode == 2'b11) ? RECS_CYC
                                                    : RECL_CYC;
        end
    end

endmodule

// file: bench/ncs_regs_sva.sv
// concurrent checks on the configuration and setup register bank ports
`timescale 1ns/1ps
`include "ncs_defines.vh"
module ncs_regs_sva #(
    parameter RECON_LONG_CYC  = 840,
    parameter RECON_SHORT_CYC = 420
) (
    input wire        clk,
    input wire        rstn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        lineOutA_n,
    input wire        lineOutAOe,
    input wire        lineOutB_n,
    input wire        driverEnable_n,
    input wire        softReset,
    input wire [1:0]  registerSelectBits,
    input wire        registerSelectTop,
    input wire [31:0] responseCycles,
    input wire [31:0] idleCycles,
    input wire [31:0] reconfigCycles
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] cfg_q, ctl_q, su1_q;  // shadows of what software wrote
    wire wrDone = psel & penable & pready & pwrite & !pslverr;
    // shadows move at the completing edge, same edge the lines follow
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= 8'h00;
            ctl_q <= 8'h00;
            su1_q <= 8'h00;
        end else if (wrDone) begin
            if (paddr == `NCS_ADDR_CONFIG) cfg_q <= pwdata[7:0];
            if (paddr == `NCS_ADDR_CONTROL) ctl_q <= pwdata[7:0];
            if (paddr == `NCS_ADDR_SETUP1) su1_q <= pwdata[7:0];
        end
    end
    // response length in 10 ns cycles per timeout code
    function automatic logic [31:0] respOf(input logic [1:0] c);
        return c == 2'h0 ? 32'd59660 : c == 2'h1 ? 32'd29840 :
               c == 2'h2 ? 32'd14920 : 32'd3740;
    endfunction
    function automatic logic [31:0] idleOf(input logic [1:0] c);
        return c == 2'h0 ? 32'd65600 : c == 2'h1 ? 32'd32800 :
               c == 2'h2 ? 32'd16400 : 32'd4100;
    endfunction
    sequence sCfgWr;
        psel && penable && pready && pwrite && paddr == `NCS_ADDR_CONFIG;
    endsequence
    a_gate_holds_idle: assert property (
        !cfg_q[5] && $past(!cfg_q[5]) |->
        driverEnable_n && (lineOutA_n || !lineOutAOe) &&
        (cfg_q[2] || $past(cfg_q[2]) || lineOutB_n))
        else $error("transmit outputs active with gate low");
    a_gate_lets_drive: assert property (cfg_q[5] && ctl_q[0] &&
        $stable({cfg_q, ctl_q}) |-> !driverEnable_n)
        else $error("driver enable held off with gate high");
    // checked from the second reset edge on: the first edge of a
    // power-up reset is the one that loads the reset values
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn ##1 !rstn |-> driverEnable_n && lineOutA_n &&
        lineOutB_n && !lineOutAOe)
        else $error("outputs not idle in reset");
    a_style_picks_driver: assert property (cfg_q[2] && !ctl_q[1] &&
        $stable({cfg_q, su1_q, ctl_q}) |-> lineOutAOe == su1_q[7])
        else $error("pulse A driver type wrong");
    a_resp_time: assert property (sCfgWr |=>
        responseCycles == respOf($past(pwdata[4:3])))
        else $error("response length wrong");
    a_idle_time: assert property (sCfgWr |=>
        idleCycles == idleOf($past(pwdata[4:3])))
        else $error("idle length wrong");
    a_recon_time: assert property (sCfgWr |=> reconfigCycles ==
        ($past(pwdata[4:3]) == 2'h3 ? RECON_SHORT_CYC : RECON_LONG_CYC))
        else $error("reconfiguration length wrong");
    a_select_follow: assert property (sCfgWr |=>
        !registerSelectTop && registerSelectBits == $past(pwdata[1:0]))
        else $error("selector not taken from config write");
    a_soft_reset_copy: assert property (sCfgWr |=>
        softReset == $past(pwdata[7]))
        else $error("soft reset bit not copied");
endmodule
bind ncs_net_config_setup_regs ncs_regs_sva #(
    .RECON_LONG_CYC (RECON_LONG_CYC),
    .RECON_SHORT_CYC(RECON_SHORT_CYC)
) u_sva (.*);

// file: bench/ncs_media_model.sv
// far-side model: sends bursts of refusal replies as level pulses
`timescale 1ns/1ps
module ncs_media_model (
    input  wire       clk,
    input  wire       go,
    input  wire [7:0] burstLen,
    output logic      nackSeen
);
    initial nackSeen = 1'b0;
    // each refusal is two cycles high, two low, so every edge is seen
    always @(posedge clk) begin
        if (go) begin
            for (int i = 0; i < burstLen; i++) begin
                nackSeen <= 1'b1;
                repeat (2) @(posedge clk);
                nackSeen <= 1'b0;
                repeat (2) @(posedge clk);
            end
        end
    end
endmodule

// file: bench/testbench.sv
// self-checking bench for the configuration and setup register bank
`timescale 1ns/1ps
`include "ncs_defines.vh"
module testbench;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        go = 0, slv;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [7:0]  burstLen = 0;
    wire  [31:0] prdata, responseCycles, idleCycles, reconfigCycles;
    wire         pready, pslverr, nackSeen, lineOutA_n, lineOutAOe;
    wire         lineOutB_n, driverEnable_n, softReset, irq;
    wire         registerSelectTop;
    wire  [1:0]  registerSelectBits;
    int          err_count = 0, checks = 0;
    // expected timer lengths in 10 ns cycles, indexed by timeout code
    int          respExp[4] = '{59660, 29840, 14920, 3740};
    int          idleExp[4] = '{65600, 32800, 16400, 4100};
    always #5 clk = ~clk;
    // short reconfiguration counts keep the run brief
    ncs_net_config_setup_regs #(.RECON_LONG_CYC(840),
        .RECON_SHORT_CYC(420)) i_dut (.*);
    ncs_media_model i_media (.*);
    task final_report;
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer; holds the request until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            final_report;
        end
        rd = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // outputs follow the registers after a cycle; sample once settled
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task burst(input logic [7:0] n);
        @(posedge clk);
        go <= 1; burstLen <= n;
        @(posedge clk);
        go <= 0;
        repeat (4 * n + 8) @(posedge clk);
    endtask
    // watchdog against a hang anywhere
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1;
        rdc(`NCS_ADDR_CONFIG, 32'h0);
        rdc(`NCS_ADDR_SETUP1, 32'h0);
        // every timeout code, the same on all nodes
        for (int c = 0; c < 4; c++) begin
            wr(`NCS_ADDR_CONFIG, c << 3);
            settle;
            chk(responseCycles, respExp[c]);
            chk(idleCycles, idleExp[c]);
            chk(reconfigCycles, c == 3 ? 420 : 840);
        end
        wr(`NCS_ADDR_CONTROL, 32'h7);
        settle;
        chk({driverEnable_n, lineOutA_n, lineOutB_n}, 3'h7);
        wr(`NCS_ADDR_CONFIG, 32'h20);
        settle;
        chk({driverEnable_n, lineOutA_n, lineOutB_n}, 3'h0);
        rdc(`NCS_ADDR_IRQSTAT, 32'h1);
        wr(`NCS_ADDR_CONTROL, 32'h1);
        wr(`NCS_ADDR_CONFIG, 32'h24);
        settle;
        chk(lineOutAOe, 1'b0);
        wr(`NCS_ADDR_SETUP1, 32'h80);
        settle;
        chk(lineOutAOe, 1'b1);
        rdc(`NCS_ADDR_SETUP1, 32'h80);
        wr(`NCS_ADDR_CONFIG, 32'h04);
        wr(`NCS_ADDR_CONTROL, 32'h4);
        settle;
        chk({driverEnable_n, lineOutB_n}, 2'h2);
        wr(`NCS_ADDR_SUBADDR, 32'h7);
        rdc(`NCS_ADDR_SUBADDR, 32'h7);
        chk(registerSelectTop, 1'b1);
        wr(`NCS_ADDR_CONFIG, 32'h82);
        rdc(`NCS_ADDR_SUBADDR, 32'h2);
        chk(registerSelectBits, 2'h2);
        rdc(`NCS_ADDR_CONFIG, 32'h82);
        chk(softReset, 1'b1);
        wr(`NCS_ADDR_CONFIG, 32'h02);
        apb(1'b0, 12'h01c, 32'h0);
        chk({31'h0, slv}, 32'h1);
        chk(rd, 32'h0);
        wr(`NCS_ADDR_IRQMASK, 32'h2);
        wr(`NCS_ADDR_SETUP1, 32'h40);
        burst(3);
        rdc(`NCS_ADDR_DIAG, 32'h3);
        burst(1);
        rdc(`NCS_ADDR_DIAG, 32'h100);
        chk(irq, 1'b1);
        rdc(`NCS_ADDR_IRQSTAT, 32'h2);
        settle;
        chk(irq, 1'b0);
        // second reset in mid-run brings the default threshold back
        @(posedge clk);
        rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        rdc(`NCS_ADDR_CONFIG, 32'h0);
        burst(127);
        rdc(`NCS_ADDR_DIAG, 32'h7f);
        burst(1);
        rdc(`NCS_ADDR_DIAG, 32'h100);
        final_report;
    end
endmodule
